// *** verilog/vat_pkg.sv ***
// Functional notes
// - Three mapping schemes give 16-bit, 18-bit or 22-bit physical addresses.
// - I/O page always sits at octal 17 760 000 to 17 777 777.
// - 16-bit mapping passes low 28 K unchanged; top 4 K goes to I/O page.
// - 18-bit mapping maps each 32 K mode space into 128 K physical words.
// - 22-bit mapping emits full address; top 4 K still decodes as I/O page.
// - A page holds 1 to 128 blocks of 64 bytes, at most 8192 bytes.
// - Page start is a multiple of 64 bytes, anywhere in physical space.
// - Register set chosen by processor mode and instruction or data reference.
// - With relocation on, vector fetches use kernel data-space registers.
// - Vector PC and status words both map through kernel data-space registers.
// - Bits 15:14 of the new status word pick the following register set.
// - Instruction-type references use I space; all others use D space.
// - A per-mode control bit disables D space so every reference in that mode uses I space.
// - Top 3 virtual bits select one of 8 page base registers.
// - Low 13 bits are offset: 7-bit block above 6-bit byte offset.
// - Each page base register holds a 16-bit physical block number.
// - Virtual block plus base block forms physical address bits 21:6.
// - The 6-bit in-block offset is appended unchanged below the block.
// - Access code 00 and 10 abort all, 01 aborts writes, 11 permits all.
// - Length error when block above limit growing up, below limit growing down.
package vat_pkg;

  localparam int          VA_W      = 16;
  localparam int          PA_W      = 22;
  localparam int          NREG      = 48;
  localparam logic [5:0]  NREG_L    = 6'h30;

  // Register map, byte addresses
  localparam logic [11:0] OFF_CFG   = 12'h000;
  localparam logic [11:0] OFF_STAT  = 12'h004;
  localparam logic [3:0]  REG_PAR   = 4'h1;    // 0x100..0x1bc
  localparam logic [3:0]  REG_PDR   = 4'h2;    // 0x200..0x2bc

  // Mapping schemes
  localparam logic [1:0]  MAP16     = 2'h0;
  localparam logic [1:0]  MAP18     = 2'h1;
  localparam logic [1:0]  MAP22     = 2'h2;

  // Processor modes as carried in status bits 15:14
  localparam logic [1:0]  MODE_KERN = 2'h0;
  localparam logic [1:0]  MODE_SUP  = 2'h1;
  localparam logic [1:0]  MODE_ILL  = 2'h2;
  localparam logic [1:0]  MODE_USER = 2'h3;
  localparam logic [1:0]  MIDX_USER = 2'h2;

  localparam logic [2:0]  PAGE_IO16 = 3'h7;
  localparam logic [8:0]  IO_PFX    = 9'h1ff;  // octal 17 760 000 >> 13
  localparam logic [4:0]  IO18_PFX  = 5'h1f;
  localparam logic [3:0]  PAD18_IO  = 4'hf;
  localparam logic [3:0]  PAD18_MEM = 4'h0;
  localparam logic [5:0]  PAD16     = 6'h00;
  localparam logic [8:0]  BLK_PAD   = 9'h000;

  // Access codes
  localparam logic [1:0]  ACF_RO    = 2'h1;
  localparam logic [1:0]  ACF_RW    = 2'h3;

  // Descriptor fields
  localparam int          PLF_HI    = 14;
  localparam int          PLF_LO    = 8;
  localparam int          WR_BIT    = 6;
  localparam int          ED_BIT    = 3;
  localparam int          ACF_HI    = 2;
  localparam int          ACF_LO    = 1;
  localparam logic [15:0] PDR_WMASK = 16'hff0e;

  // Status fields
  localparam int          ST_NRES   = 15;
  localparam int          ST_LEN    = 14;
  localparam int          ST_RO     = 13;

  localparam logic [31:0] ZERO32    = 32'h0000_0000;
  localparam logic [15:0] ZERO16    = 16'h0000;
  localparam logic [21:0] ZERO22    = 22'h000000;

  typedef struct packed {
    logic        valid;    // Request strobe
    logic [15:0] vaddr;    // Virtual byte address
    logic [15:0] processor_status_word;      // Current status word image
    logic        ispace;   // Instruction-space reference
    logic        write;    // Write access
    logic        vector;   // Trap/interrupt vector fetch
  } vat_req_t;

  typedef struct packed {
    logic        valid;
    logic [21:0] paddr;
    logic        io_page;
    logic        ab_nres;
    logic        ab_len;
    logic        ab_ro;
  } vat_resp_t;

endpackage

// *** verilog/vat_translator.sv ***
`timescale 1ns/10ps
`default_nettype none
module vat_translator
  import vat_pkg::*;
(
  input  wire logic        pclk,     // 50 MHz clock
  input  wire logic        presetn,  // Async reset, active low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [11:0] paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error, unmapped address
  input  wire vat_req_t    core_req, // Translation request
  output vat_resp_t        core_resp // Translation result, one cycle later
);

  typedef struct packed {
    logic [1:0]            map;
    logic [2:0]            dsp_en;   // Per mode: kernel, supervisor, user
    logic [47:0][15:0]     par;
    logic [47:0][15:0]     page_limits_descriptor;
    logic [2:0]            flags;    // Sticky aborts: nonres, length, read-only
    logic [1:0]            ab_mode;
    logic                  ab_space;
    logic [2:0]            ab_page;
    logic [31:0]           rdata;
    logic                  ready;
    logic                  slverr;
    vat_resp_t             resp;
  } vat_state_t;

  vat_state_t s_r;
  vat_state_t s_nxt;

  // Bus decode
  logic        bus_setup;
  logic        bus_wr;
  logic        hit_cfg;
  logic        hit_stat;
  logic        hit_par;
  logic        hit_pdr;
  logic [5:0]  ridx;
  logic [31:0] rd_val;

  // Translation
  logic        reloc;
  logic [1:0]  eff_mode;
  logic        mode_ill;
  logic [1:0]  midx;
  logic        use_d;
  logic [2:0]  page;
  logic [6:0]  blk;
  logic [5:0]  idx;
  logic [15:0] par_v;
  logic [15:0] pdr_v;
  logic [15:0] phys_blk;
  logic [21:0] pa22;
  logic [17:0] pa18;
  logic [21:0] pa_out;
  logic        ab_nres;
  logic        ab_len;
  logic        ab_ro;
  logic [6:0]  plf;
  logic [1:0]  acf;
  logic [2:0]  new_flags;
  logic [2:0]  clr_flags;
  logic [15:0] kd_blk;

  always_comb begin
    bus_setup = psel & ~penable;
    bus_wr    = psel & penable & s_r.ready & pwrite & ~s_r.slverr;
    ridx      = paddr[7:2];
    hit_cfg   = paddr == OFF_CFG;
    hit_stat  = paddr == OFF_STAT;
    hit_par   = (paddr[11:8] == REG_PAR) && (paddr[1:0] == 2'h0) && (ridx < NREG_L);
    hit_pdr   = (paddr[11:8] == REG_PDR) && (paddr[1:0] == 2'h0) && (ridx < NREG_L);
    rd_val    = ZERO32;
    if (hit_cfg) begin
      rd_val[4:0] = {s_r.dsp_en, s_r.map};
    end else if (hit_stat) begin
      rd_val[15:0] = {s_r.flags, 6'h00, s_r.ab_mode, s_r.ab_space, s_r.ab_page, 1'b0};
    end else if (hit_par) begin
      rd_val[15:0] = s_r.par[ridx];
    end else if (hit_pdr) begin
      rd_val[15:0] = s_r.page_limits_descriptor[ridx];
    end
  end

  always_comb begin
    reloc    = s_r.map != MAP16;
    // Vector fetches are forced onto the kernel set; later fetches follow
    // the mode bits of whatever status word the core has loaded since.
    eff_mode = (core_req.vector & reloc) ? MODE_KERN
                                         : core_req.processor_status_word[15:14];
    mode_ill = eff_mode == MODE_ILL;
    case (eff_mode)
      MODE_SUP:  midx = MODE_SUP;
      MODE_USER: midx = MIDX_USER;
      default:   midx = MODE_KERN;
    endcase
    // Vector words take the data group; D disabled folds onto I
    use_d    = (core_req.vector | ~core_req.ispace)
               & s_r.dsp_en[midx];
    page     = core_req.vaddr[15:13];
    blk      = core_req.vaddr[12:6];
    idx      = {midx, use_d, page};
    par_v    = s_r.par[idx];
    pdr_v    = s_r.page_limits_descriptor[idx];
    // Base counts 64-byte blocks, so pages start on block edges
    phys_blk = par_v + {BLK_PAD, blk};
    pa22     = {phys_blk, core_req.vaddr[5:0]};
    pa18     = pa22[17:0];
    case (s_r.map)
      MAP18: begin
        pa_out = (pa18[17:13] == IO18_PFX) ? {PAD18_IO, pa18}
                                           : {PAD18_MEM, pa18};
      end
      MAP22: begin
        pa_out = pa22;
      end
      default: begin
        pa_out = (page == PAGE_IO16) ? {IO_PFX, core_req.vaddr[12:0]}
                                     : {PAD16, core_req.vaddr};
      end
    endcase
    acf      = pdr_v[ACF_HI:ACF_LO];
    plf      = pdr_v[PLF_HI:PLF_LO];
    ab_nres  = reloc & (mode_ill | ~acf[0]);
    ab_ro    = reloc & ~ab_nres & core_req.write & (acf == ACF_RO);
    ab_len   = reloc & ~mode_ill & (pdr_v[ED_BIT] ? (blk < plf)
                                                   : (blk > plf));
    new_flags = core_req.valid ? {ab_nres, ab_len, ab_ro} : 3'h0;
    clr_flags = (bus_wr & hit_stat) ? pwdata[ST_NRES:ST_RO] : 3'h0;
    kd_blk   = s_r.par[{MODE_KERN, 1'b1, page}] + {BLK_PAD, blk};
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ready  = 1'b0;
    s_nxt.slverr = 1'b0;
    if (bus_setup) begin
      s_nxt.ready  = 1'b1;
      s_nxt.slverr = ~(hit_cfg | hit_stat | hit_par | hit_pdr);
      s_nxt.rdata  = rd_val;
    end
    if (bus_wr & hit_cfg) begin
      s_nxt.map    = pwdata[1:0];
      s_nxt.dsp_en = pwdata[4:2];
    end
    // Writing either half of a pair clears that page's written mark
    if (bus_wr & hit_par) begin
      s_nxt.par[ridx]         = pwdata[15:0];
      s_nxt.page_limits_descriptor[ridx][WR_BIT] = 1'b0;
    end
    if (bus_wr & hit_pdr) begin
      s_nxt.page_limits_descriptor[ridx] = (s_r.page_limits_descriptor[ridx] & ~PDR_WMASK) | (pwdata[15:0] & PDR_WMASK);
      s_nxt.page_limits_descriptor[ridx][WR_BIT] = 1'b0;
    end
    // Later assignment wins, so a hardware mark beats a same-cycle clear
    if (core_req.valid & core_req.write & reloc & ~(ab_nres | ab_len | ab_ro)) begin
      s_nxt.page_limits_descriptor[idx][WR_BIT] = 1'b1;
    end
    // Abort details freeze on the first fault until software clears it
    if ((new_flags != 3'h0) && (s_r.flags == 3'h0)) begin
      s_nxt.ab_mode  = eff_mode;
      s_nxt.ab_space = use_d;
      s_nxt.ab_page  = page;
    end
    s_nxt.flags         = (s_r.flags & ~clr_flags) | new_flags;
    s_nxt.resp.valid    = core_req.valid;
    s_nxt.resp.paddr    = core_req.valid ? pa_out : s_r.resp.paddr;
    s_nxt.resp.io_page  = core_req.valid ? (pa_out[21:13] == IO_PFX)
                                         : s_r.resp.io_page;
    s_nxt.resp.ab_nres  = core_req.valid & ab_nres;
    s_nxt.resp.ab_len   = core_req.valid & ab_len;
    s_nxt.resp.ab_ro    = core_req.valid & ab_ro;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata    = s_r.rdata;
  assign pready    = s_r.ready;
  assign pslverr   = s_r.slverr;
  assign core_resp = s_r.resp;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_low16_pass: assert property (
    core_req.valid && s_r.map == MAP16 && core_req.vaddr[15:13] != PAGE_IO16
    |=> core_resp.valid && core_resp.paddr == {PAD16, $past(core_req.vaddr)})
    else $error("16-bit low space not passed through");

  chk_io16_redirect: assert property (
    core_req.valid && s_r.map == MAP16 && core_req.vaddr[15:13] == PAGE_IO16
    |=> core_resp.io_page && core_resp.paddr[12:0] == $past(core_req.vaddr[12:0]))
    else $error("16-bit top page not sent to I/O page");

  chk_pa18_range: assert property (
    core_req.valid && s_r.map == MAP18
    |=> core_resp.paddr[21:18] == PAD18_MEM
        || (core_resp.paddr[21:13] == IO_PFX))
    else $error("18-bit result outside memory or I/O page");

  chk_offset_kept: assert property (
    core_req.valid && s_r.map != MAP16
    |=> core_resp.paddr[5:0] == $past(core_req.vaddr[5:0]))
    else $error("In-block offset altered");

  chk_vector_kdata: assert property (
    core_req.valid && core_req.vector && s_r.map == MAP22 && s_r.dsp_en[0]
    |=> core_resp.paddr[21:6] == $past(kd_blk))
    else $error("Vector not mapped through kernel data set");

  chk_ro_abort: assert property (
    core_req.valid && s_r.map != MAP16 && core_req.write && !mode_ill && acf == ACF_RO
    |=> core_resp.ab_ro && !core_resp.ab_nres)
    else $error("Write to read-only page not aborted");

  chk_rw_noabort: assert property (
    core_req.valid && !mode_ill && acf == ACF_RW
    |=> !core_resp.ab_nres && !core_resp.ab_ro)
    else $error("Read/write page aborted");

  chk_len_up: assert property (
    core_req.valid && s_r.map != MAP16 && !mode_ill && !pdr_v[ED_BIT] && blk > plf
    |=> core_resp.ab_len ##1 s_r.flags[1])
    else $error("Upward length error missed");

  chk_illegal_mode: assert property (
    core_req.valid && s_r.map != MAP16 && !core_req.vector && core_req.processor_status_word[15:14] == MODE_ILL
    |=> core_resp.ab_nres)
    else $error("Illegal mode not aborted");

  chk_apb_ready: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("APB ready not exactly one access cycle");

  // Register bus handshake
  chk_ready_idle: assert property (
    !psel
    |=> !pready)
    else $error("APB ready without a setup cycle");

  chk_err_ready: assert property (
    pslverr
    |-> pready)
    else $error("APB error raised outside the access cycle");

  chk_err_rdata: assert property (
    pslverr
    |-> prdata == ZERO32)
    else $error("Unmapped read returned data");

  chk_rdata_upper: assert property (
    pready && !pslverr
    |-> prdata[31:16] == ZERO16)
    else $error("Reserved read bits not zero");

  chk_cfg_commit: assert property (
    psel && penable && pready && pwrite && !pslverr && paddr == OFF_CFG
    |=> s_r.map == $past(pwdata[1:0]))
    else $error("Mapping scheme write lost");

  chk_par_commit: assert property (
    bus_wr && hit_par
    |=> s_r.par[$past(ridx)] == $past(pwdata[15:0]))
    else $error("Page base write lost");

  // Translation answer timing
  chk_resp_pulse: assert property (
    core_req.valid
    |=> core_resp.valid)
    else $error("Translation answer missing");

  chk_resp_idle: assert property (
    !core_req.valid
    |=> !core_resp.valid)
    else $error("Translation answer without request");

  chk_abort_valid: assert property (
    core_resp.ab_nres || core_resp.ab_len || core_resp.ab_ro
    |-> core_resp.valid)
    else $error("Abort flag outside an answer");

  chk_io_flag: assert property (
    core_resp.valid
    |-> core_resp.io_page == (core_resp.paddr[21:13] == IO_PFX))
    else $error("I/O page flag disagrees with address");

  // Mapping schemes
  chk_map16_noabort: assert property (
    core_req.valid && s_r.map == MAP16
    |=> !core_resp.ab_nres && !core_resp.ab_len && !core_resp.ab_ro)
    else $error("Abort raised with relocation off");

  chk_offset16: assert property (
    core_req.valid && s_r.map == MAP16
    |=> core_resp.paddr[12:0] == $past(core_req.vaddr[12:0]))
    else $error("16-bit page offset altered");

  chk_map22_block: assert property (
    core_req.valid && s_r.map == MAP22
    |=> core_resp.paddr[21:6] == $past(par_v + {BLK_PAD, core_req.vaddr[12:6]}))
    else $error("Physical block is not base plus virtual block");

  chk_map18_mem: assert property (
    core_req.valid && s_r.map == MAP18 && pa18[17:13] != IO18_PFX
    |=> core_resp.paddr[21:18] == PAD18_MEM && !core_resp.io_page)
    else $error("18-bit memory reference left low memory");

  // Register set selection
  chk_page_index: assert property (
    core_req.valid
    |-> idx[2:0] == core_req.vaddr[15:13])
    else $error("Page field does not pick the register");

  chk_ispace_sel: assert property (
    core_req.valid && reloc && core_req.ispace && !core_req.vector
    |-> !use_d)
    else $error("Instruction reference mapped through D space");

  chk_dspace_off: assert property (
    core_req.valid && reloc && !s_r.dsp_en[midx]
    |-> !use_d)
    else $error("D space used while disabled");

  chk_vector_mode: assert property (
    core_req.valid && core_req.vector && reloc
    |-> eff_mode == MODE_KERN)
    else $error("Vector word not mapped in kernel mode");

  chk_vector_dset: assert property (
    core_req.valid && core_req.vector && reloc && s_r.dsp_en[0]
    |-> idx[5:3] == 3'h1)
    else $error("Vector word not in kernel data group");

  chk_status_mode: assert property (
    core_req.valid && !core_req.vector
    |-> eff_mode == core_req.processor_status_word[15:14])
    else $error("Mode not taken from status word");

  // Access control and length
  chk_nres_code: assert property (
    core_req.valid && reloc && !acf[0]
    |=> core_resp.ab_nres && !core_resp.ab_ro)
    else $error("Nonresident page not aborted");

  chk_len_down: assert property (
    core_req.valid && reloc && !mode_ill && pdr_v[ED_BIT] && blk < plf
    |=> core_resp.ab_len)
    else $error("Downward length error missed");

  // Sticky status flags
  chk_nres_sticky: assert property (
    s_r.flags[2] && !(bus_wr && hit_stat && pwdata[ST_NRES])
    |=> s_r.flags[2])
    else $error("Nonresident flag lost without a clear");

  chk_ro_clear: assert property (
    bus_wr && hit_stat && pwdata[ST_RO] && !new_flags[0]
    |=> !s_r.flags[0])
    else $error("Read-only flag not cleared");

endmodule // vat_translator
`default_nettype wire

// *** testbench/vat_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module vat_core_model
  import vat_pkg::*;
(
  input  wire logic      pclk, // Core clock
  output vat_req_t       req,  // Requests toward the translator
  input  wire vat_resp_t resp  // Translated answer
);
  initial req = '0;

  // One request, one cycle strobe; the answer is read mid-cycle, clear of the edge
  task automatic xlate(input logic [15:0] va, ps, input logic i, w, v, output vat_resp_t r);
    @(posedge pclk);
    req <= '{1'b1, va, ps, i, w, v};
    @(posedge pclk);
    // Stale fields are inverted so a design that ignores valid shows it
    req <= '{1'b0, ~va, ~ps, ~i, ~w, ~v};
    @(negedge pclk);
    r = resp;
  endtask
endmodule // vat_core_model
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  import vat_pkg::*;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        pready;
  logic        pslverr;
  logic        e;
  logic [1:0]  a;
  logic [1:0]  md;
  vat_req_t    req;
  vat_resp_t   resp;
  vat_resp_t   r;
  int          fail_count = 0;
  int          tests_run = 0;

  always #10 pclk = ~pclk;

  vat_translator DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_req(req), .core_resp(resp));
  vat_core_model core (.pclk(pclk), .req(req), .resp(resp));

  task close_out;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // The slave's latency is not assumed: wait for pready, bounded
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
    chk({31'h0, e}, 32'h0);
  endtask

  task rd(input logic [11:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(q, x);
  endtask

  task tx(input logic [15:0] va, ps, input logic i, w, v, input logic [21:0] pa,
          input logic io, n, l, o);
    core.xlate(va, ps, i, w, v, r);
    chk({5'h0, r}, {5'h0, 1'b1, pa, io, n, l, o});
  endtask

  initial begin
    #1_000_000;
    fail_count++;
    close_out;
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(OFF_CFG, 32'h0);
    tx(16'h1234, 16'h0, 1, 0, 0, 22'h001234, 0, 0, 0, 0);
    tx(16'he010, 16'h0, 1, 0, 0, 22'h3fe010, 1, 0, 0, 0);
    apb(1'b0, 12'h300, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(OFF_CFG, 32'h6);
    rd(OFF_CFG, 32'h6);
    for (int m = 0; m < 3; m++) begin
      md = (m == 2) ? 2'b11 : 2'(m);
      wr(12'h104 + 12'(m * 64), 32'h1000 + m);
      wr(12'h204 + 12'(m * 64), 32'h7f06);
      tx(16'h216a, {md, 14'h0}, 1, 0, 0, {16'(16'h1005 + m), 6'h2a}, 0, 0, 0, 0);
    end
    wr(12'h124, 32'h0200);
    wr(12'h224, 32'h7f06);
    tx(16'h216a, 16'h0, 0, 0, 0, {16'h0205, 6'h2a}, 0, 0, 0, 0);
    tx(16'h216a, 16'hc000, 1, 0, 1, {16'h0205, 6'h2a}, 0, 0, 0, 0);
    tx(16'h216c, 16'hc000, 1, 0, 1, {16'h0205, 6'h2c}, 0, 0, 0, 0);
    wr(OFF_CFG, 32'h2);
    tx(16'h216a, 16'h0, 0, 0, 0, {16'h1005, 6'h2a}, 0, 0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      a = 2'(k);
      wr(12'h204, 32'h7f00 | {29'h0, a, 1'b0});
      tx(16'h216a, 16'h0, 1, 1, 0, {16'h1005, 6'h2a}, 0, ~a[0], 0, a == 2'h1);
    end
    rd(12'h204, 32'h7f46);
    wr(12'h204, 32'h0406);
    tx(16'h2140, 16'h0, 1, 0, 0, {16'h1005, 6'h00}, 0, 0, 1, 0);
    tx(16'h2100, 16'h0, 1, 0, 0, {16'h1004, 6'h00}, 0, 0, 0, 0);
    wr(12'h204, 32'h040e);
    tx(16'h20c0, 16'h0, 1, 0, 0, {16'h1003, 6'h00}, 0, 0, 1, 0);
    tx(16'h2100, 16'h0, 1, 0, 0, {16'h1004, 6'h00}, 0, 0, 0, 0);
    core.xlate(16'h2000, 16'h8000, 1, 0, 0, r);
    chk({31'h0, r.ab_nres}, 32'h1);
    wr(OFF_CFG, 32'h1);
    wr(12'h204, 32'h7f06);
    wr(12'h104, 32'h0ff8);
    tx(16'h2000, 16'h0, 1, 0, 0, 22'h3ffe00, 1, 0, 0, 0);
    wr(12'h104, 32'h1010);
    tx(16'h2000, 16'h0, 1, 0, 0, 22'h000400, 0, 0, 0, 0);
    close_out;
  end
endmodule // tb
`default_nettype wire
